// ### verilog/lpsc_power_ctrl.sv
`timescale 1ns/1ps
`include "lpsc_cfg.svh"

////////////////////////////////////////////////////////////////////////////////
module lpsc_power_ctrl
  import lpsc_pkg::*;
#(
  parameter logic [15:0] FRAME_CYCLES = `LPSC_FRAME_CYCLES
) (
  input  wire logic        mclk,
  input  wire logic        reset_n,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  input  wire logic        hw_power_save_pin,
  input  wire logic        link_clk,
  input  wire logic [11:0] refresh_pixels,
  output logic             refresh_enable,
  output logic             host_bus_enable,
  output logic             panel_power_enable,
  output logic      [11:0] panel_pixel_bus,
  output logic             panel_shift_clock,
  output logic             panel_line_pulse,
  output logic             panel_frame_pulse,
  output logic             panel_data_valid,
  output logic             core_clock_stop_ok
);

  ////////////////////////////////////////////////////////////////////////////////
  // Register file (mclk domain)
  logic [1:0] mode_control_register;
  logic [1:0] cfg_reg;
  logic [3:0] gpio_reg;
  logic       hwps_sync;
  logic       hw_save;
  lpsc_mode_t mode;
  lpsc_mode_t mode_next;

  function automatic lpsc_mode_t decode_mode(input logic hw, input logic [1:0] bits);
    if (hw)
      return LPSC_MD_HWSAVE;
    else if (bits == `LPSC_MODE_NORMAL)
      return LPSC_MD_NORMAL;
    else if (bits == `LPSC_MODE_SWSAVE)
      return LPSC_MD_SWSAVE;
    else
      return LPSC_MD_RESV;
  endfunction

  lpsc_sync #(.WIDTH(1)) u_hwps_sync (
    .clk     (mclk),
    .reset_n (reset_n),
    .d       (hw_power_save_pin),
    .q       (hwps_sync)
  );

  assign hw_save   = hwps_sync & cfg_reg[`LPSC_CFG_HWPS_BIT];
  assign mode_next = decode_mode(hw_save, mode_control_register);

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n)
      mode <= LPSC_MD_SWSAVE;
    else
      mode <= mode_next;
  end

  // Writes are dropped while the bus interface is shut off
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      mode_control_register <= `LPSC_MODE_RST;
      cfg_reg               <= `LPSC_CFG_RST;
      gpio_reg              <= 4'h0;
    end else if (reg_wr && !hw_save) begin
      unique case (reg_addr)
        `LPSC_MODE_OFF: mode_control_register <= reg_wdata[1:0];
        `LPSC_CFG_OFF:  cfg_reg  <= reg_wdata[1:0];
        `LPSC_GPIO_OFF: gpio_reg <= reg_wdata[3:0];
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Crossing into the link domain: mode and gpio as stable levels
  logic       link_reset_n;
  logic       link_rst_meta;
  logic       want_on_link;
  logic       hold_gpio_link;
  logic [3:0] gpio_link;
  logic       want_on_reg;

  // Registered before the crossing so the synchroniser never sees a decode glitch
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n)
      want_on_reg <= 1'b0;
    else
      want_on_reg <= (mode == LPSC_MD_NORMAL);
  end

  always_ff @(posedge link_clk or negedge reset_n) begin
    if (!reset_n) begin
      link_rst_meta <= 1'b0;
      link_reset_n  <= 1'b0;
    end else begin
      link_rst_meta <= 1'b1;
      link_reset_n  <= link_rst_meta;
    end
  end

  lpsc_sync #(.WIDTH(1)) u_on_sync (
    .clk     (link_clk),
    .reset_n (link_reset_n),
    .d       (want_on_reg),
    .q       (want_on_link)
  );

  lpsc_sync #(.WIDTH(5)) u_gpio_sync (
    .clk     (link_clk),
    .reset_n (link_reset_n),
    .d       ({cfg_reg[`LPSC_CFG_GPIO_BIT], gpio_reg}),
    .q       ({hold_gpio_link, gpio_link})
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Panel sequencer (link domain)
  lpsc_seq_t  seq_reg;
  lpsc_seq_t  seq_next;
  logic [6:0] seq_cnt_reg;
  logic [7:0] off_cnt_reg;
  logic       frame_tick;
  logic       delay_done;
  logic       phase;

  lpsc_frame_timer #(.FRAME_CYCLES(FRAME_CYCLES)) u_frame (
    .link_clk     (link_clk),
    .link_reset_n (link_reset_n),
    .run          (1'b1),
    .frame_tick   (frame_tick)
  );

  assign delay_done = frame_tick && (seq_cnt_reg == `LPSC_SEQ_FRAMES - 7'd1);

  always_comb begin
    seq_next = seq_reg;
    unique case (seq_reg)
      LPSC_ST_OFF:     if (want_on_link) seq_next = LPSC_ST_PWR_ON;
      LPSC_ST_PWR_ON:  seq_next = LPSC_ST_WAIT_UP;
      LPSC_ST_WAIT_UP: begin
        if (!want_on_link)
          seq_next = LPSC_ST_WAIT_DN;
        else if (delay_done)
          seq_next = LPSC_ST_ACTIVE;
      end
      LPSC_ST_ACTIVE:  if (!want_on_link) seq_next = LPSC_ST_WAIT_DN;
      LPSC_ST_WAIT_DN: if (delay_done) seq_next = LPSC_ST_OFF;
      default:         seq_next = LPSC_ST_OFF;
    endcase
  end

  always_ff @(posedge link_clk or negedge link_reset_n) begin
    if (!link_reset_n)
      seq_reg <= LPSC_ST_OFF;
    else
      seq_reg <= seq_next;
  end

  // Delay counter restarts on every state change
  always_ff @(posedge link_clk or negedge link_reset_n) begin
    if (!link_reset_n)
      seq_cnt_reg <= 7'd0;
    else if (seq_next != seq_reg)
      seq_cnt_reg <= 7'd0;
    else if (frame_tick && seq_cnt_reg != `LPSC_SEQ_FRAMES)
      seq_cnt_reg <= seq_cnt_reg + 7'd1;
  end

  // Frames spent powered down; saturates at the core clock stop point
  always_ff @(posedge link_clk or negedge link_reset_n) begin
    if (!link_reset_n)
      off_cnt_reg <= 8'd0;
    else if (want_on_link)
      off_cnt_reg <= 8'd0;
    else if (frame_tick && off_cnt_reg != `LPSC_CLK_STOP_FR)
      off_cnt_reg <= off_cnt_reg + 8'd1;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Panel outputs; sequence order: power first, then signals (pixel bus [11:8] excepted under gpio hold); reverse on the way down
  assign phase = (seq_reg == LPSC_ST_ACTIVE);

  always_ff @(posedge link_clk or negedge link_reset_n) begin
    if (!link_reset_n) begin
      panel_power_enable <= 1'b0;
      panel_pixel_bus    <= 12'h000;
      panel_shift_clock  <= 1'b0;
      panel_line_pulse   <= 1'b0;
      panel_frame_pulse  <= 1'b0;
      panel_data_valid   <= 1'b0;
    end else begin
      panel_power_enable <= (seq_reg != LPSC_ST_OFF);
      panel_shift_clock  <= phase & ~panel_shift_clock;
      panel_line_pulse   <= phase & frame_tick;
      panel_frame_pulse  <= phase & frame_tick;
      panel_data_valid   <= phase;
      panel_pixel_bus[7:0] <= phase ? refresh_pixels[7:0] : 8'h00;
      if (hold_gpio_link)
        panel_pixel_bus[11:8] <= gpio_link;
      else
        panel_pixel_bus[11:8] <= phase ? refresh_pixels[11:8] : 4'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Status back to mclk
  logic active_link_reg;
  logic stop_ok_link_reg;

  // Both status bits come straight from flops; a compare feeding a synchroniser could glitch
  always_ff @(posedge link_clk or negedge link_reset_n) begin
    if (!link_reset_n) begin
      active_link_reg  <= 1'b0;
      stop_ok_link_reg <= 1'b0;
    end else begin
      active_link_reg  <= phase;
      stop_ok_link_reg <= (off_cnt_reg == `LPSC_CLK_STOP_FR);
    end
  end

  logic active_mclk;
  logic stop_ok_mclk;

  lpsc_sync #(.WIDTH(2)) u_stat_sync (
    .clk     (mclk),
    .reset_n (reset_n),
    .d       ({active_link_reg, stop_ok_link_reg}),
    .q       ({active_mclk, stop_ok_mclk})
  );

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      refresh_enable     <= 1'b0;
      host_bus_enable    <= 1'b0;
      core_clock_stop_ok <= 1'b0;
    end else begin
      refresh_enable     <= active_mclk && (mode == LPSC_MD_NORMAL);
      host_bus_enable    <= !hw_save;
      core_clock_stop_ok <= stop_ok_mclk && (mode != LPSC_MD_NORMAL);
    end
  end

  // Read data one cycle after the strobe; zero when refused or unmapped
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n)
      reg_rdata <= 8'h00;
    else if (reg_rd && !hw_save) begin
      unique case (reg_addr)
        `LPSC_MODE_OFF:   reg_rdata <= {6'h00, mode_control_register};
        `LPSC_CFG_OFF:    reg_rdata <= {6'h00, cfg_reg};
        `LPSC_STATUS_OFF: reg_rdata <= {4'h0, stop_ok_mclk, active_mclk, mode};
        `LPSC_GPIO_OFF:   reg_rdata <= {4'h0, gpio_reg};
        default:          reg_rdata <= 8'h00;
      endcase
    end else
      reg_rdata <= 8'h00;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  hwsave_refuse_a: assert property (@(posedge mclk) disable iff (!reset_n)
    (reg_rd && hw_save) |=> (reg_rdata == 8'h00)) else $error("read served in hw save");

  hwsave_decode_a: assert property (@(posedge mclk) disable iff (!reset_n)
    hw_save |=> (mode == LPSC_MD_HWSAVE)) else $error("hw save not selected");

  normal_decode_a: assert property (@(posedge mclk) disable iff (!reset_n)
    (!hw_save && mode_control_register == 2'b11) |=> (mode == LPSC_MD_NORMAL))
    else $error("normal mode not decoded");

  resv_off_a: assert property (@(posedge mclk) disable iff (!reset_n)
    (mode == LPSC_MD_RESV) |-> !refresh_enable || $past(mode) == LPSC_MD_NORMAL)
    else $error("refresh in reserved mode");

  refresh_gate_a: assert property (@(posedge mclk) disable iff (!reset_n)
    (mode != LPSC_MD_NORMAL) |=> !refresh_enable) else $error("refresh in save mode");

  off_panel_a: assert property (@(posedge link_clk) disable iff (!link_reset_n)
    (seq_reg == LPSC_ST_OFF) |=> !panel_power_enable && !panel_data_valid)
    else $error("panel driven while off");

  delay_len_a: assert property (@(posedge link_clk) disable iff (!link_reset_n)
    (seq_reg == LPSC_ST_WAIT_DN && delay_done) |=> (seq_reg == LPSC_ST_OFF))
    else $error("power-down delay wrong");

  seq_order_a: assert property (@(posedge link_clk) disable iff (!link_reset_n)
    (seq_reg == LPSC_ST_ACTIVE && !want_on_link) |=> (seq_reg == LPSC_ST_WAIT_DN))
    else $error("power-down not started");

  gpio_hold_a: assert property (@(posedge link_clk) disable iff (!link_reset_n)
    hold_gpio_link |=> (panel_pixel_bus[11:8] == $past(gpio_link)))
    else $error("gpio level lost");

  bus_off_a: assert property (@(posedge mclk) disable iff (!reset_n)
    hw_save |=> !host_bus_enable)
    else $error("bus enabled in hw save");

  write_refuse_a: assert property (@(posedge mclk) disable iff (!reset_n)
    (reg_wr && hw_save) |=> $stable(mode_control_register))
    else $error("write taken in hw save");

  stop_gate_a: assert property (@(posedge mclk) disable iff (!reset_n)
    (mode == LPSC_MD_NORMAL) |=> !core_clock_stop_ok)
    else $error("clock stop allowed in normal");

  timing_low_a: assert property (@(posedge link_clk) disable iff (!link_reset_n)
    (seq_reg == LPSC_ST_WAIT_DN) |=> !panel_shift_clock && !panel_line_pulse && !panel_frame_pulse)
    else $error("timing active in power down");

  pixel_low_a: assert property (@(posedge link_clk) disable iff (!link_reset_n)
    (seq_reg != LPSC_ST_ACTIVE) |=> (panel_pixel_bus[7:0] == 8'h00))
    else $error("pixels driven while inactive");

  power_first_a: assert property (@(posedge link_clk) disable iff (!link_reset_n)
    (seq_reg == LPSC_ST_PWR_ON) |=> panel_power_enable && !panel_data_valid)
    else $error("power-up order wrong");

  rdata_idle_a: assert property (@(posedge mclk) disable iff (!reset_n)
    !reg_rd |=> (reg_rdata == 8'h00))
    else $error("read data without strobe");

endmodule

// ### verilog/lpsc_cfg.svh
`ifndef LPSC_CFG_SVH
`define LPSC_CFG_SVH

// Register offsets on the plain register port
`define LPSC_MODE_OFF       4'h3
`define LPSC_CFG_OFF        4'h4
`define LPSC_STATUS_OFF     4'h5
`define LPSC_GPIO_OFF       4'h6

// Mode register fields
`define LPSC_MODE_NORMAL    2'b11
`define LPSC_MODE_SWSAVE    2'b00
`define LPSC_MODE_RST       2'b00

// Configuration register fields
`define LPSC_CFG_HWPS_BIT   0
`define LPSC_CFG_GPIO_BIT   1
`define LPSC_CFG_RST        2'b00

// Sequencing counts, in frames
`define LPSC_SEQ_FRAMES     7'd127
`define LPSC_CLK_STOP_FR    8'd128

// Frame period on the link clock, in link clock cycles
`define LPSC_FRAME_CYCLES   16'd1000

`endif

// ### verilog/lpsc_pkg.sv
package lpsc_pkg;

  typedef enum logic [1:0] {
    LPSC_MD_NORMAL = 2'b00,
    LPSC_MD_SWSAVE = 2'b01,
    LPSC_MD_HWSAVE = 2'b10,
    LPSC_MD_RESV   = 2'b11
  } lpsc_mode_t;

  typedef enum logic [2:0] {
    LPSC_ST_OFF     = 3'b000,
    LPSC_ST_PWR_ON  = 3'b001,
    LPSC_ST_WAIT_UP = 3'b010,
    LPSC_ST_ACTIVE  = 3'b011,
    LPSC_ST_WAIT_DN = 3'b100
  } lpsc_seq_t;

endpackage

// ### verilog/lpsc_sync.sv
`timescale 1ns/1ps
// Two-stage level synchroniser
module lpsc_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             reset_n,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_reg;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_reg <= '0;
      q        <= '0;
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end
endmodule

// ### verilog/lpsc_frame_timer.sv
`timescale 1ns/1ps
`include "lpsc_cfg.svh"
// Frame tick generator on the link clock; one pulse per frame period
module lpsc_frame_timer #(
  parameter logic [15:0] FRAME_CYCLES = `LPSC_FRAME_CYCLES
) (
  input  wire logic link_clk,
  input  wire logic link_reset_n,
  input  wire logic run,
  output logic      frame_tick
);
  logic [15:0] cnt_reg;

  always_ff @(posedge link_clk or negedge link_reset_n) begin
    if (!link_reset_n) begin
      cnt_reg    <= 16'h0000;
      frame_tick <= 1'b0;
    end else if (!run) begin
      cnt_reg    <= 16'h0000;
      frame_tick <= 1'b0;
    end else if (cnt_reg == FRAME_CYCLES - 16'h0001) begin
      cnt_reg    <= 16'h0000;
      frame_tick <= 1'b1;
    end else begin
      cnt_reg    <= cnt_reg + 16'h0001;
      frame_tick <= 1'b0;
    end
  end
endmodule

// ### tb/lpsc_panel_model.sv
`timescale 1ns/1ps
module lpsc_panel_model (
  input  wire logic        link_clk,
  input  wire logic        panel_power_enable,
  input  wire logic        panel_shift_clock,
  input  wire logic        panel_line_pulse,
  input  wire logic        panel_frame_pulse,
  input  wire logic        panel_data_valid,
  output logic      [11:0] refresh_pixels,
  output logic             fault
);
  initial begin
    refresh_pixels = 12'h5a5;
    fault          = 1'b0;
  end

  // Pattern flips between two values every cycle so a sample one cycle stale never passes as fresh
  always @(posedge link_clk) begin
    refresh_pixels <= ~refresh_pixels + 12'h001;
    // A panel without supply must never see timing edges
    if (!panel_power_enable && (panel_shift_clock | panel_line_pulse |
        panel_frame_pulse | panel_data_valid)) begin
      fault <= 1'b1;
    end
  end
endmodule

// ### tb/lcd_power_save_control_tb.sv
`timescale 1ns/1ps
`include "lpsc_cfg.svh"
module lcd_power_save_control_tb;
  logic        mclk;
  logic        link_clk;
  logic        reset_n;
  logic [3:0]  reg_addr;
  logic [7:0]  reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [7:0]  reg_rdata;
  logic        hw_power_save_pin;
  logic [11:0] refresh_pixels;
  logic        refresh_enable;
  logic        host_bus_enable;
  logic        panel_power_enable;
  logic [11:0] panel_pixel_bus;
  logic        panel_shift_clock;
  logic        panel_line_pulse;
  logic        panel_frame_pulse;
  logic        panel_data_valid;
  logic        core_clock_stop_ok;
  logic        fault;
  logic [7:0]  d;
  int          n;
  int          n_mismatch;
  int          checked;
  realtime     t0;

  lpsc_power_ctrl #(.FRAME_CYCLES(16'd4)) uut (
    .mclk(mclk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .hw_power_save_pin(hw_power_save_pin), .link_clk(link_clk),
    .refresh_pixels(refresh_pixels), .refresh_enable(refresh_enable),
    .host_bus_enable(host_bus_enable), .panel_power_enable(panel_power_enable),
    .panel_pixel_bus(panel_pixel_bus), .panel_shift_clock(panel_shift_clock),
    .panel_line_pulse(panel_line_pulse), .panel_frame_pulse(panel_frame_pulse),
    .panel_data_valid(panel_data_valid), .core_clock_stop_ok(core_clock_stop_ok)
  );

  lpsc_panel_model panel (
    .link_clk(link_clk), .panel_power_enable(panel_power_enable),
    .panel_shift_clock(panel_shift_clock), .panel_line_pulse(panel_line_pulse),
    .panel_frame_pulse(panel_frame_pulse), .panel_data_valid(panel_data_valid),
    .refresh_pixels(refresh_pixels), .fault(fault)
  );

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  // Phase offset keeps the two domains unrelated
  initial begin
    link_clk = 1'b0;
    #3;
    forever #7.5 link_clk = ~link_clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Bus clock runs free and accesses are spaced by whole cycles
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge mclk);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge mclk);
    reg_wr    <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge mclk);
    reg_rd   <= 1'b0;
    #1;
    v = reg_rdata;
  endtask

  // 127 frames of 4 link cycles at 15 ns, with slack for sync and sampling
  task automatic chk_delay(input string nm);
    n = int'($realtime - t0);
    chk(nm, 16'(n > 7500 && n < 7900), 16'h0001);
  endtask

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    #200000;
    n_mismatch++;
    complete_run;
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    n_mismatch = 0;
    checked = 0;
    reset_n = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    hw_power_save_pin = 1'b0;
    repeat (6) @(posedge mclk);
    reset_n <= 1'b1;
    #1;
    chk("power", panel_power_enable, 16'h0);
    chk("pixels", panel_pixel_bus, 16'h0);
    rd(`LPSC_MODE_OFF, d);
    chk("mode", d, 16'h00);
    rd(`LPSC_STATUS_OFF, d);
    chk("status", d & 8'h07, 16'h01);
    rd(4'hf, d);
    chk("unmapped", d, 16'h00);
    $display("test reset done");

    for (int i = 1; i < 3; i++) begin
      wr(`LPSC_MODE_OFF, 8'(i));
      repeat (40) @(posedge mclk);
      chk("resv power", panel_power_enable, 16'h0);
      rd(`LPSC_STATUS_OFF, d);
      chk("resv mode", d & 8'h03, 16'h03);
    end
    $display("test reserved done");

    wr(`LPSC_CFG_OFF, 8'h02);
    wr(`LPSC_GPIO_OFF, 8'h0a);
    wr(`LPSC_MODE_OFF, 8'h03);
    for (n = 0; n < 20 && panel_power_enable !== 1'b1; n++) @(posedge mclk);
    chk("power up", panel_power_enable, 16'h1);
    t0 = $realtime;
    for (n = 0; n < 400 && panel_data_valid !== 1'b1; n++) @(posedge mclk);
    chk_delay("up delay");
    for (n = 0; n < 8 && refresh_enable !== 1'b1; n++) @(posedge mclk);
    chk("refresh on", refresh_enable, 16'h1);
    chk("stop ok normal", core_clock_stop_ok, 16'h0);
    chk("gpio active", panel_pixel_bus[11:8], 16'ha);
    rd(`LPSC_STATUS_OFF, d);
    chk("status active", d & 8'h07, 16'h04);
    $display("test power up done");

    wr(`LPSC_MODE_OFF, 8'h00);
    t0 = $realtime;
    for (n = 0; n < 10 && refresh_enable !== 1'b0; n++) @(posedge mclk);
    chk("refresh off", refresh_enable, 16'h0);
    repeat (4) @(posedge mclk);
    chk("power held", panel_power_enable, 16'h1);
    chk("valid low", panel_data_valid, 16'h0);
    chk("shift low", panel_shift_clock, 16'h0);
    for (n = 0; n < 400 && panel_power_enable !== 1'b0; n++) @(posedge mclk);
    chk_delay("down delay");
    chk("pixels save", panel_pixel_bus, 16'h0a00);
    rd(`LPSC_GPIO_OFF, d);
    chk("gpio read", d, 16'h0a);
    $display("test power down done");

    wr(`LPSC_CFG_OFF, 8'h03);
    @(posedge mclk);
    hw_power_save_pin <= 1'b1;
    for (n = 0; n < 10 && host_bus_enable !== 1'b0; n++) @(posedge mclk);
    chk("bus off", host_bus_enable, 16'h0);
    wr(`LPSC_MODE_OFF, 8'h03);
    rd(`LPSC_MODE_OFF, d);
    chk("refused read", d, 16'h00);
    for (n = 0; n < 300 && core_clock_stop_ok !== 1'b1; n++) @(posedge mclk);
    chk("stop ok hw", core_clock_stop_ok, 16'h1);
    chk("power hw", panel_power_enable, 16'h0);
    @(posedge mclk);
    hw_power_save_pin <= 1'b0;
    for (n = 0; n < 10 && host_bus_enable !== 1'b1; n++) @(posedge mclk);
    rd(`LPSC_MODE_OFF, d);
    chk("write lost", d, 16'h00);
    rd(`LPSC_STATUS_OFF, d);
    chk("hw exit mode", d & 8'h03, 16'h01);
    chk("panel fault", fault, 16'h0);
    $display("test hw save done");
    complete_run;
  end
endmodule
